// file: src/pcfs_pkg.sv
// Package: register offsets, field positions and sizes of the per-channel function select bank
package pcfs_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NUM_FUNC = 8;
    localparam int NUM_MAP = 4;
    localparam logic [ADDR_W-1:0] OFF_POINTER = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_MAP1 = 8'h29;
    localparam logic [ADDR_W-1:0] OFF_MAP4 = 8'h2c;
    localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;
    localparam logic [DATA_W-1:0] MAP_RST = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_RD = 8'h00;
    // Pointer bit positions
    localparam int BIT_BERT_TX = 0;
    localparam int BIT_FRAC_TX = 1;
    localparam int BIT_PAYLOAD_ERR = 2;
    localparam int BIT_HW_SIG_TX = 3;
    localparam int BIT_BERT_RX = 4;
    localparam int BIT_FRAC_RX = 5;
    localparam int BIT_SIG_REINS_RX = 6;
    localparam int BIT_SIG_ONES_RX = 7;
    localparam logic [DATA_W-1:0] PTR_BERT_BOTH = 8'h11;
    typedef enum logic [1:0] {PCFS_ACC_IDLE, PCFS_ACC_WRITE, PCFS_ACC_READ} pcfs_acc_e;
endpackage : pcfs_pkg

// file: src/pcfs_reg_if.sv
// Interface: decoded register access from the bus front end to the store
`timescale 1ns/1ps
interface pcfs_reg_if;
    logic ptr_wr;
    logic map_wr;
    logic [1:0] map_idx;
    logic [pcfs_pkg::DATA_W-1:0] wdata;
    logic [pcfs_pkg::DATA_W-1:0] pointer;
    modport front (output ptr_wr, output map_wr, output map_idx, output wdata, input pointer);
    modport store (input ptr_wr, input map_wr, input map_idx, input wdata, output pointer);
endinterface : pcfs_reg_if

// file: src/pcfs_decode.sv
// Address decoder for the pointer and channel-map data registers
`timescale 1ns/1ps
module pcfs_decode (
    input wire logic [pcfs_pkg::ADDR_W-1:0] addr,
    input wire logic wr_stb,
    input wire logic [pcfs_pkg::DATA_W-1:0] wdata,
    pcfs_reg_if.front bus
);
    logic in_map;
    logic [pcfs_pkg::ADDR_W-1:0] map_off;

    always_comb begin
        in_map = (addr >= pcfs_pkg::OFF_MAP1) && (addr <= pcfs_pkg::OFF_MAP4);
        map_off = addr - pcfs_pkg::OFF_MAP1;
        bus.ptr_wr = wr_stb && (addr == pcfs_pkg::OFF_POINTER);
        bus.map_wr = wr_stb && in_map;
        bus.map_idx = map_off[1:0];
        bus.wdata = wdata;
    end
endmodule : pcfs_decode

// file: src/pcfs_top.sv
// Top: per-channel function pointer, channel-map data registers and per-function masks
`timescale 1ns/1ps
module pcfs_top #(
    parameter int NUM_CHAN = 32
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [pcfs_pkg::ADDR_W-1:0] addr,
    input wire logic [pcfs_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [pcfs_pkg::DATA_W-1:0] rdata,
    output logic [NUM_CHAN-1:0] bert_tx_chan_sel,
    output logic [NUM_CHAN-1:0] frac_tx_chan_sel,
    output logic [NUM_CHAN-1:0] payload_err_ins_chan_sel,
    output logic [NUM_CHAN-1:0] hw_sig_tx_chan_sel,
    output logic [NUM_CHAN-1:0] bert_rx_chan_sel,
    output logic [NUM_CHAN-1:0] frac_rx_chan_sel,
    output logic [NUM_CHAN-1:0] sig_reinsert_rx_chan_sel,
    output logic [NUM_CHAN-1:0] sig_all_ones_rx_chan_sel
);
    localparam int MAP_BITS = pcfs_pkg::DATA_W * pcfs_pkg::NUM_MAP;

    if (NUM_CHAN != MAP_BITS) begin : g_bad_chan
        $error("NUM_CHAN must equal the bits of the four map registers");
    end

    typedef logic [MAP_BITS-1:0] pcfs_mask_t;

    pcfs_reg_if rif ();
    logic [pcfs_pkg::DATA_W-1:0] pointer_reg;
    pcfs_mask_t mask_reg [pcfs_pkg::NUM_FUNC];
    logic [pcfs_pkg::DATA_W-1:0] rdata_next;

    // Lowest set pointer bit picks the feature a read returns
    function automatic int pcfs_first_func(input logic [pcfs_pkg::DATA_W-1:0] p);
        int f;
        f = 0;
        for (int i = pcfs_pkg::NUM_FUNC - 1; i >= 0; i--) begin
            if (p[i]) begin
                f = i;
            end
        end
        return f;
    endfunction : pcfs_first_func

    pcfs_decode u_decode (
        .addr(addr),
        .wr_stb(wr_stb),
        .wdata(wdata),
        .bus(rif.front)
    );

    assign rif.pointer = pointer_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pointer_reg <= pcfs_pkg::POINTER_RST;
        end else if (rif.ptr_wr) begin
            pointer_reg <= rif.wdata;
        end
    end

    // One mask per feature; a multi-bit pointer writes several at once
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int f = 0; f < pcfs_pkg::NUM_FUNC; f++) begin
                mask_reg[f] <= '0;
            end
        end else if (rif.map_wr) begin
            for (int f = 0; f < pcfs_pkg::NUM_FUNC; f++) begin
                if (pointer_reg[f]) begin
                    mask_reg[f][rif.map_idx*pcfs_pkg::DATA_W +: pcfs_pkg::DATA_W] <= rif.wdata;
                end
            end
        end
    end

    // Read with several pointer bits set is undefined use; lowest bit wins
    always_comb begin
        rdata_next = pcfs_pkg::UNMAPPED_RD;
        if (addr == pcfs_pkg::OFF_POINTER) begin
            rdata_next = pointer_reg;
        end else if (addr >= pcfs_pkg::OFF_MAP1 && addr <= pcfs_pkg::OFF_MAP4) begin
            rdata_next = mask_reg[pcfs_first_func(pointer_reg)]
                [rif.map_idx*pcfs_pkg::DATA_W +: pcfs_pkg::DATA_W];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= pcfs_pkg::MAP_RST;
        end else if (rd_stb) begin
            rdata <= rdata_next;
        end else begin
            rdata <= pcfs_pkg::UNMAPPED_RD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bert_tx_chan_sel <= '0;
            frac_tx_chan_sel <= '0;
            payload_err_ins_chan_sel <= '0;
            hw_sig_tx_chan_sel <= '0;
            bert_rx_chan_sel <= '0;
            frac_rx_chan_sel <= '0;
            sig_reinsert_rx_chan_sel <= '0;
            sig_all_ones_rx_chan_sel <= '0;
        end else begin
            bert_tx_chan_sel <= mask_reg[pcfs_pkg::BIT_BERT_TX];
            frac_tx_chan_sel <= mask_reg[pcfs_pkg::BIT_FRAC_TX];
            payload_err_ins_chan_sel <= mask_reg[pcfs_pkg::BIT_PAYLOAD_ERR];
            hw_sig_tx_chan_sel <= mask_reg[pcfs_pkg::BIT_HW_SIG_TX];
            bert_rx_chan_sel <= mask_reg[pcfs_pkg::BIT_BERT_RX];
            frac_rx_chan_sel <= mask_reg[pcfs_pkg::BIT_FRAC_RX];
            sig_reinsert_rx_chan_sel <= mask_reg[pcfs_pkg::BIT_SIG_REINS_RX];
            sig_all_ones_rx_chan_sel <= mask_reg[pcfs_pkg::BIT_SIG_ONES_RX];
        end
    end

    property p_ptr_write;
        @(posedge sys_clk) disable iff (srst)
        (wr_stb && addr == pcfs_pkg::OFF_POINTER) |=> (pointer_reg == $past(wdata));
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer not written");

    property p_map_sel;
        @(posedge sys_clk) disable iff (srst)
        (wr_stb && addr == pcfs_pkg::OFF_MAP1 && pointer_reg[pcfs_pkg::BIT_BERT_TX])
            |=> ##1 (bert_tx_chan_sel[7:0] == $past(wdata, 2));
    endproperty
    a_map_sel: assert property (p_map_sel) else $error("bert tx map not updated");

    property p_unsel_kept;
        @(posedge sys_clk) disable iff (srst)
        (rif.map_wr && !pointer_reg[pcfs_pkg::BIT_FRAC_RX])
            |=> $stable(mask_reg[pcfs_pkg::BIT_FRAC_RX]);
    endproperty
    a_unsel_kept: assert property (p_unsel_kept) else $error("unselected mask changed");

    property p_both_bert;
        @(posedge sys_clk) disable iff (srst)
        (wr_stb && addr == pcfs_pkg::OFF_MAP4 && pointer_reg == pcfs_pkg::PTR_BERT_BOTH)
            |=> ##1 (bert_tx_chan_sel[31:24] == bert_rx_chan_sel[31:24]);
    endproperty
    a_both_bert: assert property (p_both_bert) else $error("bert directions differ");

    property p_read_back;
        @(posedge sys_clk) disable iff (srst)
        (rd_stb && addr == pcfs_pkg::OFF_MAP1 + 8'h01 && pointer_reg == 8'h04)
            |=> (rdata == payload_err_ins_chan_sel[15:8]);
    endproperty
    a_read_back: assert property (p_read_back) else $error("map read mismatch");

    property p_ptr_read;
        @(posedge sys_clk) disable iff (srst)
        (rd_stb && addr == pcfs_pkg::OFF_POINTER) |=> (rdata == $past(pointer_reg));
    endproperty
    a_ptr_read: assert property (p_ptr_read) else $error("pointer read mismatch");

    property p_hwsig;
        @(posedge sys_clk) disable iff (srst)
        (wr_stb && addr == pcfs_pkg::OFF_MAP1 + 8'h02 && pointer_reg == 8'h08)
            |=> ##1 (hw_sig_tx_chan_sel[23:16] == $past(wdata, 2));
    endproperty
    a_hwsig: assert property (p_hwsig) else $error("hw sig map not updated");

    property p_idle_rdata;
        @(posedge sys_clk) disable iff (srst)
        !rd_stb |=> (rdata == pcfs_pkg::UNMAPPED_RD);
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data without strobe");

    c_multi_write: cover property (@(posedge sys_clk) rif.map_wr && pointer_reg == 8'h11);
    c_map_read: cover property (@(posedge sys_clk) rd_stb && addr == pcfs_pkg::OFF_MAP4);
    c_ptr_write: cover property (@(posedge sys_clk) rif.ptr_wr);
    c_unmapped_write: cover property (@(posedge sys_clk) wr_stb && addr > pcfs_pkg::OFF_MAP4);
    c_reset_seen: cover property (@(posedge sys_clk) srst ##1 !srst);

    // Reset clears masks and read data whatever was stored before
    property p_reset_clear;
        @(posedge sys_clk)
        srst |=> (bert_tx_chan_sel == '0 && sig_all_ones_rx_chan_sel == '0
            && rdata == pcfs_pkg::UNMAPPED_RD);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

    property p_unmapped_wr;
        @(posedge sys_clk) disable iff (srst)
        (wr_stb && addr > pcfs_pkg::OFF_MAP4) |=> $stable(pointer_reg);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

    property p_ptr_hold;
        @(posedge sys_clk) disable iff (srst)
        !rif.ptr_wr |=> $stable(pointer_reg);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed unasked");

    property p_frac_tx;
        @(posedge sys_clk) disable iff (srst)
        (rif.map_wr && pointer_reg[pcfs_pkg::BIT_FRAC_TX] && rif.map_idx == 2'h3)
            |=> ##1 (frac_tx_chan_sel[31:24] == $past(wdata, 2));
    endproperty
    a_frac_tx: assert property (p_frac_tx) else $error("frac tx map not updated");

    property p_ones_rx;
        @(posedge sys_clk) disable iff (srst)
        (rif.map_wr && pointer_reg[pcfs_pkg::BIT_SIG_ONES_RX] && rif.map_idx == 2'h0)
            |=> ##1 (sig_all_ones_rx_chan_sel[7:0] == $past(wdata, 2));
    endproperty
    a_ones_rx: assert property (p_ones_rx) else $error("all-ones map not updated");

    // Map read returns the selected feature's byte of the same cycle
    property p_rx_read;
        @(posedge sys_clk) disable iff (srst)
        (rd_stb && addr == pcfs_pkg::OFF_MAP1 && pointer_reg == 8'h10)
            |=> (rdata == bert_rx_chan_sel[7:0]);
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("bert rx read mismatch");
endmodule : pcfs_top

// file: verif/pcfs_top_test.sv
// Testbench for the per-channel function select bank
`timescale 1ns/1ps
module pcfs_top_test;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [7:0] ptr;
    logic [31:0] sel [8];
    logic [31:0] m [8];
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    // Rows: pointer, map address, data; readback of the map is the data
    logic [23:0] rows [11] = '{24'h01_29_a5, 24'h02_2a_3c, 24'h04_2b_81, 24'h08_2c_ff,
        24'h10_29_5a, 24'h20_2a_c3, 24'h40_2b_7e, 24'h80_2c_01, 24'h11_2a_0f,
        24'hff_2b_18, 24'h06_2c_42};

    pcfs_top #(.NUM_CHAN(32)) pcfs_top_i (
        .sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .bert_tx_chan_sel(sel[0]), .frac_tx_chan_sel(sel[1]),
        .payload_err_ins_chan_sel(sel[2]), .hw_sig_tx_chan_sel(sel[3]),
        .bert_rx_chan_sel(sel[4]), .frac_rx_chan_sel(sel[5]),
        .sig_reinsert_rx_chan_sel(sel[6]), .sig_all_ones_rx_chan_sel(sel[7])
    );

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Expected state follows only the documented effect of each write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int n;
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        n = int'(a) - 41;
        if (a == 8'h28) ptr = v;
        if (n >= 0 && n < 4) for (int b = 0; b < 8; b++) if (ptr[b]) m[b][8*n +: 8] = v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 v = rdata;
    endtask : rd

    // Masks reach the outputs one cycle after the write edge
    task automatic chk_masks();
        repeat (3) @(posedge sys_clk);
        #1;
        for (int b = 0; b < 8; b++) chk(sel[b], m[b]);
    endtask : chk_masks

    task automatic clr();
        ptr = 8'h00;
        for (int b = 0; b < 8; b++) m[b] = 32'h0;
    endtask : clr

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        clr();
        rd(8'h28, d);
        chk(32'(d), 32'h00);
        chk_masks();
        $display("test reset done");
        foreach (rows[i]) begin
            wr(8'h28, rows[i][23:16]);
            wr(rows[i][15:8], rows[i][7:0]);
            chk_masks();
            rd(8'h28, d);
            chk(32'(d), 32'(rows[i][23:16]));
            wr(8'h28, rows[i][23:16] & (~rows[i][23:16] + 8'h01));
            rd(rows[i][15:8], d);
            chk(32'(d), 32'(rows[i][7:0]));
        end
        $display("test table done");
        wr(8'h28, 8'h11);
        wr(8'h29, 8'h00);
        wr(8'h2a, 8'h0f);
        wr(8'h2b, 8'h18);
        wr(8'h2c, 8'h00);
        chk_masks();
        chk(sel[0], 32'h00180f00);
        chk(sel[4], 32'h00180f00);
        $display("test both directions done");
        // No feature selected and an unmapped place: nothing may change
        wr(8'h28, 8'h00);
        wr(8'h2a, 8'hff);
        wr(8'h30, 8'hff);
        chk_masks();
        rd(8'h30, d);
        chk(32'(d), 32'h00);
        rd(8'h28, d);
        chk(32'(d), 32'h00);
        $display("test refusals done");
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        clr();
        chk_masks();
        $display("test second reset done");
        conclude();
    end
endmodule : pcfs_top_test
